// *** rtl/lsrm_pkg.sv ***
// Package: code groups, thresholds, states and carriers of the lane sync and rate-match block
package lsrm_pkg;

  // Mode select values
  localparam logic MODE_GBE = 1'b0;
  localparam logic MODE_SER = 1'b1;

  // Ten-bit code groups, bit 9 is the first bit on the line
  localparam logic [9:0] K285_N = 10'h0fa;
  localparam logic [9:0] K285_P = 10'h305;
  localparam logic [9:0] K297_N = 10'h2e8;
  localparam logic [9:0] K297_P = 10'h117;
  localparam logic [9:0] D162_N = 10'h1b5;
  localparam logic [9:0] D162_P = 10'h245;
  localparam logic [9:0] D22_N  = 10'h2d5;
  localparam logic [9:0] D22_P  = 10'h125;
  localparam logic [6:0] COMMA7_N = 7'h1f;
  localparam logic [6:0] COMMA7_P = 7'h60;

  // Balanced-code ones count bounds
  localparam logic [3:0] ONES_MIN = 4'h4;
  localparam logic [3:0] ONES_MAX = 4'h6;

  // Synchronisation thresholds per mode
  localparam logic [6:0] GBE_ACQ  = 7'h03;
  localparam logic [6:0] SER_ACQ  = 7'h7f;
  localparam logic [2:0] GBE_LOSS = 3'h4;
  localparam logic [2:0] SER_LOSS = 3'h3;
  localparam logic [7:0] GBE_GOOD = 8'h04;
  localparam logic [7:0] SER_GOOD = 8'hff;

  // Rate-match FIFO geometry and watermarks
  localparam int         FIFO_DEPTH = 16;
  localparam int         PTR_W      = 5;
  localparam logic [4:0] FIFO_FULL  = 5'h10;
  localparam logic [4:0] HI_MARK    = 5'h0c;
  localparam logic [4:0] LO_MARK    = 5'h04;

  // Status flag stretch and replay lengths
  localparam logic       STRETCH_EXTRA = 1'b1;
  localparam logic [1:0] REPLAY_PAIR   = 2'h2;
  localparam logic [1:0] REPLAY_ONE    = 2'h1;

  typedef enum logic [2:0] {
    ST_LOSS = 3'b001,
    ST_ACQ  = 3'b010,
    ST_SYNC = 3'b100
  } lsrm_state_t;

  typedef struct packed {
    logic [9:0] cg;
    logic       v;
  } lsrm_cg_t;

  typedef struct packed {
    logic full;
    logic empty;
    logic del;
    logic ins;
  } lsrm_rm_flags_t;

endpackage : lsrm_pkg

// *** rtl/lsrm_sync.sv ***
// Synchronisation state machine for aligned code groups
`timescale 1ns/100ps
module lsrm_sync import lsrm_pkg::*; (
  input  wire logic i_ref_clk, // Reference clock
  input  wire logic i_rst,     // Sync reset, high
  input  wire logic i_ce,      // Clock enable
  input  wire logic i_mode,    // Protocol mode
  input  wire logic i_v,       // Group valid
  input  wire logic i_comma,   // Group is a comma
  input  wire logic i_bad,     // Group is invalid
  output logic      o_sync     // Link synchronised
);

  lsrm_state_t st_r, st_nxt;
  logic [6:0]  acq_r, acq_nxt;
  logic [2:0]  err_r, err_nxt;
  logic [7:0]  good_r, good_nxt;
  logic        odd_r, odd_nxt;

  wire       ser_mode  = (i_mode == MODE_SER);
  wire [6:0] acq_goal  = ser_mode ? SER_ACQ : GBE_ACQ;
  wire [2:0] loss_goal = ser_mode ? SER_LOSS : GBE_LOSS;
  wire [7:0] good_goal = ser_mode ? SER_GOOD : GBE_GOOD;
  // GbE comma must start on an even position so data between commas is odd
  wire       misplaced = !ser_mode && i_comma && odd_r;
  wire       bad       = i_bad || misplaced;
  wire       good_cma  = i_comma && !bad;

  always_comb begin
    st_nxt   = st_r;
    acq_nxt  = acq_r;
    err_nxt  = err_r;
    good_nxt = good_r;
    odd_nxt  = ~odd_r;
    case (st_r)
      ST_LOSS: begin
        err_nxt  = 3'h0;
        good_nxt = 8'h00;
        if (i_comma && !i_bad) begin
          st_nxt  = ST_ACQ;
          acq_nxt = 7'h01;
          odd_nxt = 1'b1;
        end
      end
      ST_ACQ: begin
        if (bad) begin
          st_nxt = ST_LOSS;
        end else if (good_cma) begin
          if (acq_r == acq_goal - 7'h01) begin
            st_nxt = ST_SYNC;
          end
          acq_nxt = acq_r + 7'h01;
        end
      end
      ST_SYNC: begin
        if (bad) begin
          good_nxt = 8'h00;
          err_nxt  = err_r + 3'h1;
          if (err_r + 3'h1 == loss_goal) begin
            st_nxt = ST_LOSS;
          end
        end else if (err_r != 3'h0) begin
          if (good_r == good_goal - 8'h01) begin
            good_nxt = 8'h00;
            err_nxt  = err_r - 3'h1;
          end else begin
            good_nxt = good_r + 8'h01;
          end
        end
      end
      default: st_nxt = ST_LOSS;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_r   <= ST_LOSS;
      acq_r  <= 7'h00;
      err_r  <= 3'h0;
      good_r <= 8'h00;
      odd_r  <= 1'b0;
      o_sync <= 1'b0;
    end else if (i_ce && i_v) begin
      st_r   <= st_nxt;
      acq_r  <= acq_nxt;
      err_r  <= err_nxt;
      good_r <= good_nxt;
      odd_r  <= odd_nxt;
      o_sync <= (st_nxt == ST_SYNC);
    end
  end

  gbe_acq_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst || !i_ce)
    $rose(o_sync) && !ser_mode |-> $past(acq_r) == 7'h02)
    else $error("gbe sync not after three sets");
  ser_acq_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst || !i_ce)
    $rose(o_sync) && ser_mode |-> $past(acq_r) == 7'h7e)
    else $error("serial sync not after 127 commas");
  gbe_loss_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst || !i_ce)
    !ser_mode && st_r == ST_SYNC && i_v && bad && err_r == 3'h3 |=> !o_sync)
    else $error("gbe sync kept at four errors");
  ser_loss_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst || !i_ce)
    ser_mode && st_r == ST_SYNC && i_v && bad && err_r == 3'h2 |=> !o_sync)
    else $error("serial sync kept at three errors");
  gbe_dec_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst || !i_ce)
    !ser_mode && st_r == ST_SYNC && i_v && !bad && err_r != 3'h0 && good_r == 8'h03
    |=> err_r == $past(err_r) - 3'h1)
    else $error("gbe error count not reduced");
  ser_dec_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst || !i_ce)
    ser_mode && st_r == ST_SYNC && i_v && !bad && err_r != 3'h0 && good_r == 8'hfe
    |=> err_r == $past(err_r) - 3'h1)
    else $error("serial error count not reduced");
  odd_comma_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst || !i_ce)
    !ser_mode && st_r == ST_ACQ && i_v && i_comma && odd_r |=> st_r == ST_LOSS)
    else $error("misplaced comma accepted");
  sync_seen_c: cover property (@(posedge i_ref_clk) disable iff (i_rst) $rose(o_sync));
  sync_lost_c: cover property (@(posedge i_ref_clk) disable iff (i_rst) $fell(o_sync));

endmodule : lsrm_sync

// *** rtl/lsrm_top.sv ***
// Lane aligner, synchronisation and rate-match FIFO for one receive channel
// Contract
// - GbE sync set: comma then odd data
// - GbE: three good sets acquire sync
// - GbE: four errors lose sync
// - GbE: four good groups drop one error
// - GbE aligner: 7-bit or 10-bit pattern
// - FIFO absorbs 200 ppm total offset
// - GbE rate match only while synced
// - GbE adds/drops whole I2 sets only
// - GbE: unlimited I2 adds/drops per gap
// - Autoneg C2 leading pair also eligible
// - Delete/insert flags pulse two cycles
// - No own escape; flag full/empty two cycles
// - Serial: 127 commas acquire sync
// - Serial: three errors lose sync
// - Serial: 255 good groups drop one error
// - Serial aligner: 10-bit pattern only
// - Serial control K28.5, skip K29.7 pairs
// - Serial: add/drop skip after control, synced
// - Serial: one skip per cluster
// - No lane deskew between channels
`timescale 1ns/100ps
module lsrm_top import lsrm_pkg::*; (
  input  wire logic     i_ref_clk, // 25 MHz clock
  input  wire logic     i_rst,     // Sync reset, high
  input  wire logic     i_ce,      // Clock enable
  input  wire logic     i_mode,    // 0 GbE, 1 serial interconnect
  input  wire logic     i_pat7,    // GbE 7-bit comma pattern
  input  wire logic     i_rm_en,   // Serial rate matcher enable
  input  wire logic     i_an_en,   // Autoneg C2 pairs eligible
  input  wire lsrm_cg_t i_raw,     // Unaligned 10-bit word
  input  wire logic     i_rd_en,   // Fabric takes a word
  output logic [9:0]    o_data,    // Aligned code group
  output logic          o_valid,   // o_data valid
  output logic          o_sync,    // Link synchronised
  output lsrm_rm_flags_t o_rm      // Rate-match status
);

  // Per-channel only: no lane-to-lane deskew here

  function automatic logic is_comma(input logic [9:0] g, input logic p7);
    is_comma = p7 ? (g[9:3] == COMMA7_N || g[9:3] == COMMA7_P)
                  : (g == K285_N || g == K285_P);
  endfunction : is_comma

  function automatic logic [3:0] ones(input logic [9:0] g);
    ones = 4'h0;
    for (int b = 0; b < 10; b++) begin
      ones = ones + {3'h0, g[b]};
    end
  endfunction : ones

  wire ser_mode = (i_mode == MODE_SER);
  wire pat7     = i_pat7 && !ser_mode;

  // Word aligner
  logic [9:0] prev_r;
  logic [3:0] off_r;
  lsrm_cg_t   cg_r;
  logic [9:0] hit;
  logic [3:0] hit_off;
  wire [19:0] win = {prev_r, i_raw.cg};

  genvar k;
  generate
    for (k = 0; k < 10; k++) begin : g_hit
      // Offsets 1..10: the current word itself is a candidate, so none is held back
      assign hit[k] = is_comma(win[18-k -: 10], pat7);
    end
  endgenerate

  always_comb begin
    hit_off = 4'h0;
    for (int j = 9; j >= 0; j--) begin
      if (hit[j]) begin
        hit_off = 4'(j);
      end
    end
  end

  // Offset is frozen once synced so a stray comma cannot slip the word
  wire       realign = i_raw.v && !o_sync && (hit != 10'h000);
  wire [3:0] sel_off = realign ? hit_off : off_r;
  wire [4:0] sel_top = 5'h12 - {1'b0, sel_off};
  wire [9:0] aligned = win[sel_top -: 10];

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      prev_r <= 10'h000;
      off_r  <= 4'h0;
      cg_r   <= '0;
    end else if (i_ce) begin
      if (i_raw.v) begin
        prev_r <= i_raw.cg;
        off_r  <= sel_off;
      end
      cg_r <= '{cg: aligned, v: i_raw.v};
    end
  end

  wire comma_now = is_comma(cg_r.cg, pat7);
  wire [3:0] n1  = ones(cg_r.cg);
  wire bad_now   = (n1 < ONES_MIN) || (n1 > ONES_MAX);

  lsrm_sync u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_ce      (i_ce),
    .i_mode    (i_mode),
    .i_v       (cg_r.v),
    .i_comma   (comma_now),
    .i_bad     (bad_now),
    .o_sync    (o_sync)
  );

  // Rate-match FIFO, depth sized for 200 ppm drift plus margin
  logic [9:0]       mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr_r;
  logic [PTR_W-1:0] rd_ptr_r;
  lsrm_cg_t         hold_r;
  logic [9:0]       last_r;
  logic [9:0]       rep_hi_r;
  logic [9:0]       rep_lo_r;
  logic [1:0]       rep_cnt_r;

  wire [PTR_W-1:0] level = wr_ptr_r - rd_ptr_r;
  wire full  = (level == FIFO_FULL);
  wire empty = (level == 5'h00);
  wire rm_on = o_sync && (!ser_mode || i_rm_en);

  // Pair detection: control word held one stage, partner in cg_r
  wire is_i2   = (cg_r.cg == D162_N) || (cg_r.cg == D162_P);
  wire is_c2   = i_an_en && ((cg_r.cg == D22_N) || (cg_r.cg == D22_P));
  wire hold_k  = hold_r.v && is_comma(hold_r.cg, 1'b0);
  wire g_pair  = !ser_mode && hold_k && (is_i2 || is_c2);
  wire s_pair  = ser_mode && ((hold_r.cg == K285_P && cg_r.cg == K297_P) ||
                          (hold_r.cg == K285_N && cg_r.cg == K297_N));
  wire del_go  = rm_on && cg_r.v && (level >= HI_MARK) && (g_pair || s_pair);
  // GbE drops comma and partner together, serial drops the skip only
  wire wr_req  = cg_r.v && hold_r.v && !(del_go && !ser_mode);
  // Full skips the write and the held word is overwritten rather than inventing room
  wire wr_ok   = wr_req && !full;

  // Read side and insertion replay
  wire       replay   = (rep_cnt_r != 2'h0);
  wire       rd_ok    = i_rd_en && !replay && !empty;
  wire [9:0] rd_word  = mem[rd_ptr_r[3:0]];
  wire       last_k   = is_comma(last_r, 1'b0);
  wire       rd_i2    = (rd_word == D162_N) || (rd_word == D162_P) ||
                        (i_an_en && ((rd_word == D22_N) || (rd_word == D22_P)));
  wire       rd_skip  = (last_r == K285_P && rd_word == K297_P) ||
                        (last_r == K285_N && rd_word == K297_N);
  wire       low      = (level - 5'h01) <= LO_MARK;
  wire       ins_go   = rd_ok && rm_on && low && last_k && (ser_mode ? rd_skip : rd_i2);
  wire [1:0] rep_load = ser_mode ? REPLAY_ONE : REPLAY_PAIR;
  wire [9:0] rep_word = (rep_cnt_r == REPLAY_PAIR) ? rep_hi_r : rep_lo_r;

  genvar e;
  generate
    for (e = 0; e < FIFO_DEPTH; e++) begin : g_mem
      always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
          mem[e] <= 10'h000;
        end else if (i_ce && wr_ok && wr_ptr_r[3:0] == 4'(e)) begin
          mem[e] <= hold_r.cg;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      hold_r   <= '0;
      wr_ptr_r <= '0;
    end else if (i_ce) begin
      if (cg_r.v) begin
        hold_r <= del_go ? '0 : cg_r;
      end
      if (wr_ok) begin
        wr_ptr_r <= wr_ptr_r + 5'h01;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rd_ptr_r  <= '0;
      rep_cnt_r <= 2'h0;
      rep_hi_r  <= 10'h000;
      rep_lo_r  <= 10'h000;
      last_r    <= 10'h000;
      o_data    <= 10'h000;
      o_valid   <= 1'b0;
    end else if (i_ce) begin
      o_valid <= i_rd_en && (replay || !empty);
      if (i_rd_en && replay) begin
        o_data    <= rep_word;
        last_r    <= rep_word;
        rep_cnt_r <= rep_cnt_r - 2'h1;
      end else if (rd_ok) begin
        o_data   <= rd_word;
        last_r   <= rd_word;
        rd_ptr_r <= rd_ptr_r + 5'h01;
        if (ins_go) begin
          rep_cnt_r <= rep_load;
          rep_hi_r  <= last_r;
          rep_lo_r  <= rd_word;
        end
      end
    end
  end

  // Status flags: each event stretched to at least two cycles
  // Flags are not sticky: the fabric must react and reset
  wire [3:0] flag_ev = {full, empty && i_rd_en && !replay, del_go, ins_go};
  logic [3:0] ext_r;
  logic [3:0] flag_r;

  genvar f;
  generate
    for (f = 0; f < 4; f++) begin : g_flag
      always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
          ext_r[f]  <= 1'b0;
          flag_r[f] <= 1'b0;
        end else if (i_ce) begin
          flag_r[f] <= flag_ev[f] || ext_r[f];
          ext_r[f]  <= flag_ev[f] & STRETCH_EXTRA;
        end
      end
    end
  endgenerate

  assign o_rm = lsrm_rm_flags_t'(flag_r);

  rm_idle_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst || !i_ce)
    !o_sync |-> !del_go && !ins_go)
    else $error("rate match active without sync");
  del_flag_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst || !i_ce)
    del_go |=> o_rm.del ##1 o_rm.del)
    else $error("delete flag not two cycles");
  ins_flag_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst || !i_ce)
    ins_go |=> o_rm.ins ##1 o_rm.ins)
    else $error("insert flag not two cycles");
  full_flag_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst || !i_ce)
    $rose(o_rm.full) |=> o_rm.full)
    else $error("full flag shorter than two cycles");
  no_overrun_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst || !i_ce)
    full && !rd_ok |=> level == FIFO_FULL)
    else $error("fifo level moved past full");
  whole_set_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst || !i_ce)
    del_go && !ser_mode |=> wr_ptr_r == $past(wr_ptr_r) && !hold_r.v)
    else $error("gigabit_ethernet_mode delete split an ordered set");
  one_skip_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst || !i_ce)
    del_go && ser_mode |=> !del_go)
    else $error("two skips deleted in one cluster");
  ins_pair_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst || !i_ce)
    ins_go && !ser_mode ##1 i_rd_en |=> o_data == $past(last_r, 2))
    else $error("gbe insert did not replay the comma");
  del_seen_c: cover property (@(posedge i_ref_clk) disable iff (i_rst) del_go);
  ins_seen_c: cover property (@(posedge i_ref_clk) disable iff (i_rst) ins_go);
  full_seen_c: cover property (@(posedge i_ref_clk) disable iff (i_rst) o_rm.full);

endmodule : lsrm_top

// *** verification/lsrm_tx_model.sv ***
// Remote transmitter model: sends code groups, idle sets and released-line idles
`timescale 1ns/100ps
module lsrm_tx_model import lsrm_pkg::*; (
  input  wire logic i_ref_clk, // Reference clock
  output lsrm_cg_t  o_raw      // Raw word towards the receiver
);
  logic [9:0] last_r = 10'h000;
  initial o_raw = '{cg: 10'h3ff, v: 1'b0};
  task automatic send(input logic [9:0] cg);
    @(posedge i_ref_clk);
    o_raw <= '{cg: cg, v: 1'b1};
    last_r = cg;
  endtask : send
  // Released line shows the inverse so a stale word is never taken
  task automatic hush(input int n);
    repeat (n) begin
      @(posedge i_ref_clk);
      o_raw <= '{cg: ~last_r, v: 1'b0};
    end
  endtask : hush
  // Idle sets in the gap, one word per cycle
  task automatic idle_sets(input int n, input logic [9:0] second);
    repeat (n) begin
      send(K285_N);
      send(second);
    end
  endtask : idle_sets
endmodule : lsrm_tx_model

// *** verification/tb.sv ***
// Self-checking testbench for the lane sync and rate-match block
`timescale 1ns/100ps
module tb;
  import lsrm_pkg::*;
  logic           i_ref_clk;
  logic           i_rst;
  logic           i_ce;
  logic           i_mode;
  logic           i_pat7;
  logic           i_rm_en;
  logic           i_an_en;
  logic           i_rd_en;
  lsrm_cg_t       i_raw;
  logic [9:0]     o_data;
  logic           o_valid;
  logic           o_sync;
  lsrm_rm_flags_t o_rm;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int n_del, n_ins, n_full, n_empty;
  int prev_k = -1;
  logic alt_on = 1'b0;

  lsrm_top lsrm_top_i (.i_ref_clk, .i_rst, .i_ce, .i_mode, .i_pat7, .i_rm_en, .i_an_en,
                       .i_raw, .i_rd_en, .o_data, .o_valid, .o_sync, .o_rm);
  lsrm_tx_model lsrm_tx_model_i (.i_ref_clk(i_ref_clk), .o_raw(i_raw));

  initial begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end

  task automatic give_verdict();
    if (num_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Flag cycle counters, pair order check on the fabric side, hang guard
  always @(posedge i_ref_clk) begin
    cycles++;
    if (o_rm.del === 1'b1) n_del++;
    if (o_rm.ins === 1'b1) n_ins++;
    if (o_rm.full === 1'b1) n_full++;
    if (o_rm.empty === 1'b1) n_empty++;
    if (alt_on && o_valid === 1'b1) begin
      if (prev_k >= 0) chk(32'((o_data === K285_N) != (prev_k == 1)), 32'h1);
      prev_k = (o_data === K285_N) ? 1 : 0;
    end
    if (cycles == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic rst_dut(input logic mode);
    @(posedge i_ref_clk);
    i_mode <= mode;
    i_rst <= 1'b1;
    i_rd_en <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    n_del = 0;
    n_ins = 0;
    n_full = 0;
    n_empty = 0;
  endtask : rst_dut

  // Flush the pipeline with the line released, then look at the sync flag
  task automatic sync_is(input logic e);
    lsrm_tx_model_i.hush(4);
    #1;
    chk(32'(o_sync), 32'(e));
  endtask : sync_is

  task automatic bad(input int n);
    repeat (n) lsrm_tx_model_i.send(10'h000);
  endtask : bad

  task automatic gbe_acq(input logic pat7);
    rst_dut(MODE_GBE);
    i_pat7 <= pat7;
    lsrm_tx_model_i.idle_sets(2, D162_P);
    sync_is(1'b0);
    lsrm_tx_model_i.idle_sets(1, D162_P);
    sync_is(1'b1);
  endtask : gbe_acq

  task automatic gbe_odd_comma();
    rst_dut(MODE_GBE);
    lsrm_tx_model_i.send(K285_N);
    lsrm_tx_model_i.send(D162_P);
    lsrm_tx_model_i.send(D162_P);
    lsrm_tx_model_i.idle_sets(2, D162_P);
    sync_is(1'b0);
  endtask : gbe_odd_comma

  task automatic gbe_loss();
    gbe_acq(1'b0);
    bad(3);
    sync_is(1'b1);
    repeat (4) lsrm_tx_model_i.send(D162_P);
    bad(1);
    sync_is(1'b1);
    bad(1);
    sync_is(1'b0);
  endtask : gbe_loss

  task automatic ser_sync(input logic rm_en);
    rst_dut(MODE_SER);
    i_pat7 <= 1'b1;
    i_rm_en <= rm_en;
    repeat (63) lsrm_tx_model_i.idle_sets(1, K285_P);
    sync_is(1'b0);
    lsrm_tx_model_i.send(K285_N);
    sync_is(1'b1);
  endtask : ser_sync

  task automatic ser_loss();
    ser_sync(1'b0);
    bad(2);
    repeat (255) lsrm_tx_model_i.send(D162_P);
    bad(1);
    sync_is(1'b1);
    bad(1);
    sync_is(1'b0);
  endtask : ser_loss

  // Control then skip pairs of both disparities into a filled buffer
  task automatic ser_skip(input logic rm_en);
    ser_sync(rm_en);
    n_del = 0;
    repeat (6) begin
      lsrm_tx_model_i.idle_sets(1, K297_N);
      lsrm_tx_model_i.send(K285_P);
      lsrm_tx_model_i.send(K297_P);
    end
    lsrm_tx_model_i.hush(4);
    chk(32'(n_del > 0), 32'(rm_en));
  endtask : ser_skip

  task automatic gbe_del(input logic an, input logic [9:0] second, input logic exp);
    gbe_acq(1'b0);
    i_an_en <= an;
    n_del = 0;
    n_full = 0;
    lsrm_tx_model_i.idle_sets(12, second);
    lsrm_tx_model_i.hush(4);
    chk(32'(exp ? n_del >= 10 : n_del == 0), 32'h1);
    chk(32'(n_full > 0), 32'(!exp));
  endtask : gbe_del

  // Comma after an even data count keeps the link down, buffer fills untouched
  task automatic gbe_nosync_full();
    rst_dut(MODE_GBE);
    repeat (8) begin
      lsrm_tx_model_i.send(K285_N);
      lsrm_tx_model_i.send(D162_P);
      lsrm_tx_model_i.send(D162_P);
    end
    sync_is(1'b0);
    chk(32'(n_del), 32'h0);
    chk(32'(n_full >= 2), 32'h1);
  endtask : gbe_nosync_full

  task automatic read_empty();
    rst_dut(MODE_GBE);
    @(posedge i_ref_clk);
    i_rd_en <= 1'b1;
    @(posedge i_ref_clk);
    i_rd_en <= 1'b0;
    #1;
    chk(32'(o_valid), 32'h0);
    repeat (4) @(posedge i_ref_clk);
    chk(32'(n_empty >= 2), 32'h1);
  endtask : read_empty

  // Balanced write and read rates keep the level low, so idle sets get replayed
  task automatic gbe_ins();
    gbe_acq(1'b0);
    @(posedge i_ref_clk);
    i_rd_en <= 1'b1;
    repeat (12) @(posedge i_ref_clk);
    n_ins = 0;
    prev_k = 1;
    alt_on = 1'b1;
    lsrm_tx_model_i.idle_sets(30, D162_P);
    repeat (8) @(posedge i_ref_clk);
    i_rd_en <= 1'b0;
    lsrm_tx_model_i.hush(4);
    alt_on = 1'b0;
    chk(32'(n_ins >= 2), 32'h1);
  endtask : gbe_ins

  initial begin
    i_rst = 1'b1;
    i_ce = 1'b1;
    i_mode = MODE_GBE;
    i_pat7 = 1'b0;
    i_rm_en = 1'b0;
    i_an_en = 1'b0;
    i_rd_en = 1'b0;
    gbe_acq(1'b0);
    gbe_acq(1'b1);
    gbe_odd_comma();
    gbe_loss();
    gbe_nosync_full();
    read_empty();
    gbe_del(1'b0, D162_P, 1'b1);
    gbe_del(1'b0, D22_P, 1'b0);
    gbe_del(1'b1, D22_P, 1'b1);
    gbe_ins();
    ser_loss();
    ser_skip(1'b0);
    ser_skip(1'b1);
    give_verdict();
  end
endmodule : tb
